// *** bench/brps_field_model.sv ***
// Field devices: firing rate motor end switches and flame sensing.
// Assumes the sequencer drives registered outputs on pclk.
`timescale 1ns/1ps
module brps_field_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic frate_high,
  input  wire logic frate_low,
  input  wire logic pilot_out,
  input  wire logic main_out,
  input  wire logic flame_ok,
  output logic      high_fire_sw,
  output logic      low_fire_sw,
  output logic      flame_in
);
  logic [3:0] hi_q;
  logic [3:0] lo_q;
  // Motor travel is slow; flame only while fuel flows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_q <= 4'h0;
      lo_q <= 4'h0;
      flame_in <= 1'b0;
    end else begin
      hi_q <= {hi_q[2:0], frate_high};
      lo_q <= {lo_q[2:0], frate_low};
      flame_in <= flame_ok & (pilot_out | main_out);
    end
  end
  assign high_fire_sw = &hi_q;
  assign low_fire_sw = &lo_q;
endmodule : brps_field_model

// *** bench/brps_seq_checker.sv ***
// Concurrent checks on the burner sequencer ports.
// Bound to brps_seq; SEC_CYC follows the instance.
`timescale 1ns/1ps
`include "brps_regs.svh"
module brps_seq_checker #(
  parameter int unsigned SEC_CYC = 10
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       demand_in,
  input wire logic       test_in,
  input wire logic       blower_out,
  input wire logic       frate_low,
  input wire logic       frate_mod,
  input wire logic       damper_out,
  input wire logic [2:0] disp_phase,
  input wire logic       disp_timed,
  input wire logic [5:0] disp_sec,
  input wire logic       disp_preempt,
  input wire logic       disp_paren
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] post_q;
  logic [15:0] run_q;
  // Cycles spent in postpurge and in run; stabilization shows as run too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_q <= 16'h0000;
      run_q  <= 16'h0000;
    end else begin
      post_q <= (disp_phase == `BRPS_DP_POST) ? post_q + 16'h0001 : 16'h0000;
      run_q  <= (disp_phase == `BRPS_DP_RUN) ? run_q + 16'h0001 : 16'h0000;
    end
  end
  a_post_blower: assert property ((disp_phase == `BRPS_DP_POST && $past(disp_phase) == `BRPS_DP_POST)
    |-> blower_out) else $error("blower off in postpurge");
  a_post_long: assert property (disp_phase == `BRPS_DP_POST |-> post_q <= 15 * SEC_CYC + 2)
    else $error("postpurge too long");
  a_post_short: assert property ($fell(disp_phase == `BRPS_DP_POST) |-> post_q >= 14 * SEC_CYC)
    else $error("postpurge too short");
  a_run_end: assert property ((disp_phase == `BRPS_DP_RUN && !demand_in) [*3]
    |-> ##[0:4] disp_phase == `BRPS_DP_POST) else $error("run did not end");
  a_test_low: assert property ((disp_phase == `BRPS_DP_RUN && test_in) [*4]
    |-> frate_low && !frate_mod) else $error("test in run not at low fire");
  a_mod_release: assert property ((disp_phase == `BRPS_DP_RUN && !test_in && run_q > 10 * SEC_CYC + 2) [*8]
    |-> frate_mod ^ damper_out) else $error("run motor output wrong");
  a_purge_hold: assert property ((disp_phase == `BRPS_DP_PURGE && test_in) [*4]
    |=> disp_phase == `BRPS_DP_PURGE) else $error("test did not hold purge");
  a_timed_show: assert property ($stable(disp_phase) |-> disp_timed == (disp_phase inside
    {`BRPS_DP_PURGE, `BRPS_DP_PILOT, `BRPS_DP_MAIN, `BRPS_DP_POST})) else $error("timer shown wrong");
  a_sec_range: assert property (disp_sec < 6'h3C) else $error("seconds out of range");
  a_paren_mark: assert property (disp_preempt && $past(disp_preempt) |-> disp_paren)
    else $error("preempt without parentheses");
  a_apb_ready: assert property (psel && penable |-> pready) else $error("no ready");
endmodule : brps_seq_checker

bind brps_seq brps_seq_checker #(.SEC_CYC(SEC_CYC)) u_brps_seq_checker (.pclk, .presetn, .psel, .penable,
  .pready, .demand_in, .test_in, .blower_out, .frate_low, .frate_mod, .damper_out, .disp_phase, .disp_timed,
  .disp_sec, .disp_preempt, .disp_paren);

// *** bench/burner_run_postpurge_test_sequencer_tb_top.sv ***
// Testbench for the burner sequencer: APB tasks and sequence scenarios.
// Assumes SEC_CYC of 10, so one second is ten cycles.
`timescale 1ns/1ps
`include "brps_regs.svh"
module burner_run_postpurge_test_sequencer_tb_top;
  localparam int unsigned SC = 10;
  logic        pclk, presetn, psel, penable, pwrite, demand_in, test_in, flame_ok, e, pready, pslverr;
  logic        pilot_trial_strap, main_trial_strap, interlock_check_strap, main_alt_term, lockout_out;
  logic        jumper_pilot_main, jumper_main_start, jumper_blower_main, flame_in, high_fire_sw, low_fire_sw;
  logic        blower_out, frate_high, frate_low, frate_mod, damper_out, pilot_out, main_out;
  logic        disp_timed, disp_arrow, disp_preempt, disp_paren;
  logic [7:0]  paddr, disp_min;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] t1;
  logic [5:0]  disp_sec;
  logic [2:0]  disp_phase;
  logic [1:0]  disp_code;
  int          n, cyc, ms, miscompares, comparisons;
  int          lo[4] = '{9, 3, 14, 9};
  int          hi[4] = '{11, 5, 17, 11};

  brps_seq #(.SEC_CYC(SC)) u_brps_seq (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .demand_in, .test_in, .flame_in, .high_fire_sw, .low_fire_sw, .pilot_trial_strap,
    .main_trial_strap, .interlock_check_strap, .main_alt_term, .jumper_pilot_main, .jumper_main_start,
    .jumper_blower_main, .blower_out, .frate_high, .frate_low, .frate_mod, .damper_out, .pilot_out, .main_out,
    .lockout_out, .disp_phase, .disp_timed, .disp_min, .disp_sec, .disp_arrow, .disp_code, .disp_preempt,
    .disp_paren);
  brps_field_model u_brps_field_model (.pclk, .presetn, .frate_high, .frate_low, .pilot_out, .main_out,
    .flame_ok, .high_fire_sw, .low_fire_sw, .flame_in);

  // Clock and hang guard
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Hold until ready is seen at an edge
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] gt);
    comparisons++;
    if (gt !== ex) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, ex, gt);
    end
  endtask : chk

  task automatic wait_ph(input logic [2:0] ph);
    n = 0;
    while (disp_phase !== ph && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    chk("phase", 32'(ph), 32'(disp_phase));
  endtask : wait_ph

  task automatic complete_run;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  initial begin
    {presetn, psel, penable, pwrite, demand_in, test_in, main_alt_term} = 7'h00;
    {jumper_pilot_main, jumper_main_start, jumper_blower_main} = 3'h0;
    {pilot_trial_strap, main_trial_strap, interlock_check_strap, flame_ok} = 4'hB;
    {paddr, pwdata, cyc, miscompares, comparisons} = '0;
    pclk = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Submenu codes, then a pending preempt after the age limit
    for (int k = 1; k < 4; k++) begin
      apb(1'b1, `BRPS_MSG_OFS, 32'(k));
      repeat (3) @(posedge pclk);
      chk("code", 32'(k), 32'(disp_code));
      chk("arrow", 32'h1, 32'(disp_arrow));
    end
    apb(1'b1, `BRPS_MSG_OFS, 32'h5);
    repeat (50 * SC) @(posedge pclk);
    chk("preempt_early", 32'h0, 32'(disp_preempt));
    repeat (11 * SC) @(posedge pclk);
    chk("preempt", 32'h1, 32'(disp_preempt));
    chk("paren", 32'h1, 32'(disp_paren));
    chk("arrow_hidden", 32'h0, 32'(disp_arrow));
    apb(1'b1, `BRPS_MSG_OFS, 32'h0);
    $display("test messages done");
    // Reset values, straps, unmapped access
    apb(1'b0, `BRPS_PURGE_OFS, 32'h0);
    chk("purge_rst", {16'h0000, `BRPS_PURGE_RST}, r);
    apb(1'b0, `BRPS_STAT_OFS, 32'h0);
    chk("straps", 32'h5, {29'h0, r[10:8]});
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", 32'h1, 32'(e));
    apb(1'b1, `BRPS_PURGE_OFS, 32'h2);
    // Full cycles across main trial options and both motor variants
    for (int i = 0; i < 4; i++) begin
      ms = (i == 1) ? 15 : (i == 2) ? 30 : 10;
      main_trial_strap <= (i == 0);
      jumper_blower_main <= (i == 2);
      main_alt_term <= (i == 3);
      apb(1'b1, `BRPS_CTRL_OFS, 32'(i == 1));
      demand_in <= 1'b1;
      wait_ph(`BRPS_DP_PURGE);
      if (i == 0) begin
        test_in <= 1'b1;
        repeat (3 * SC) @(posedge pclk);
        apb(1'b0, `BRPS_STAT_OFS, 32'h0);
        chk("prehigh_hold", 32'(brps_pkg::ST_PRE_HIGH), {28'h0, r[3:0]});
        chk("high_fire", 32'h1, 32'(frate_high));
        test_in <= 1'b0;
        // Catch the timer at one second, well before its next tick
        do apb(1'b0, `BRPS_STAT_OFS, 32'h0); while (r[31:16] == 16'h0000);
        test_in <= 1'b1;
        apb(1'b0, `BRPS_STAT_OFS, 32'h0);
        t1 = r[31:16];
        repeat (3 * SC) @(posedge pclk);
        apb(1'b0, `BRPS_STAT_OFS, 32'h0);
        chk("purge_frozen", 32'(t1), 32'(r[31:16]));
        chk("disp_sec", 32'h1, 32'(disp_sec));
        chk("disp_min", 32'h0, 32'(disp_min));
        test_in <= 1'b0;
      end
      wait_ph(`BRPS_DP_MAIN);
      chk("timed", 32'h1, 32'(disp_timed));
      wait_ph(`BRPS_DP_RUN);
      chk("main_len", 32'h1, 32'(n >= (ms - 1) * SC && n <= ms * SC + 4));
      repeat (8 * SC) @(posedge pclk);
      apb(1'b0, `BRPS_STAT_OFS, 32'h0);
      chk("stab", 32'(brps_pkg::ST_STAB), {28'h0, r[3:0]});
      repeat (3 * SC) @(posedge pclk);
      apb(1'b0, `BRPS_STAT_OFS, 32'h0);
      chk("run", 32'(brps_pkg::ST_RUN), {28'h0, r[3:0]});
      chk("motor", 32'(i != 1), 32'(frate_mod));
      chk("damper", 32'(i == 1), 32'(damper_out));
      test_in <= (i == 0);
      repeat (100) @(posedge pclk);
      chk("run_stays", 32'(`BRPS_DP_RUN), 32'(disp_phase));
      chk("low_fire", 32'(i == 0), 32'(frate_low));
      test_in <= 1'b0;
      repeat (10) @(posedge pclk);
      demand_in <= 1'b0;
      wait_ph(`BRPS_DP_POST);
      chk("blower", 32'h1, 32'(blower_out));
      wait_ph(`BRPS_DP_STANDBY);
      chk("post_len", 32'h1, 32'(n >= 14 * SC && n <= 15 * SC + 4));
      $display("test cycle %0d done", i);
    end
    // Pilot trials without flame, with and without the test selector
    flame_ok <= 1'b0;
    for (int j = 0; j < 4; j++) begin
      pilot_trial_strap <= (j != 1);
      jumper_pilot_main <= (j == 3);
      apb(1'b1, `BRPS_CTRL_OFS, (j == 3) ? 32'h2 : 32'h0);
      demand_in <= 1'b1;
      wait_ph(`BRPS_DP_PILOT);
      test_in <= (j >= 2);
      wait_ph(`BRPS_DP_LOCK);
      chk("lock_time", 32'h1, 32'(n >= lo[j] * SC && n <= hi[j] * SC));
      chk("valves", 32'h0, {30'h0, pilot_out, main_out});
      chk("lockout_out", 32'h1, 32'(lockout_out));
      test_in <= 1'b0;
      demand_in <= 1'b0;
      apb(1'b1, `BRPS_CTRL_OFS, 32'h4);
      wait_ph(`BRPS_DP_STANDBY);
      $display("test pilot %0d done", j);
    end
    complete_run();
  end
endmodule : burner_run_postpurge_test_sequencer_tb_top

// *** core/brps_pkg.sv ***
// Types shared by the burner sequencer.
// Constants live in brps_regs.svh.
package brps_pkg;
  // Sequence states
  typedef enum logic [3:0] {
    ST_STANDBY,
    ST_PRE_HIGH,
    ST_PURGE,
    ST_PRE_LOW,
    ST_PILOT,
    ST_MAIN,
    ST_STAB,
    ST_RUN,
    ST_POST,
    ST_LOCKOUT
  } brps_state_type;
endpackage : brps_pkg

// *** core/brps_regs.svh ***
// Offsets, field positions, reset values and timing figures for the burner sequencer.
// Assumes a 100 MHz clock and a one-second sequence timebase.
`ifndef BRPS_REGS_SVH
`define BRPS_REGS_SVH
// Register byte offsets
`define BRPS_CTRL_OFS     8'h00
`define BRPS_PURGE_OFS    8'h04
`define BRPS_MSG_OFS      8'h08
`define BRPS_STAT_OFS     8'h0C
// Control fields
`define BRPS_CTRL_ONOFF   0
`define BRPS_CTRL_LOCKV   1
`define BRPS_CTRL_CLR     2
`define BRPS_CTRL_RST     2'h0
`define BRPS_PURGE_RST    16'h001E
// Message fields
`define BRPS_MSG_SUB_LO   0
`define BRPS_MSG_SUB_HI   1
`define BRPS_MSG_PRE      2
`define BRPS_MSG_LOCK     3
// Display phase codes
`define BRPS_DP_STANDBY   3'h0
`define BRPS_DP_PURGE     3'h1
`define BRPS_DP_PILOT     3'h2
`define BRPS_DP_MAIN      3'h3
`define BRPS_DP_RUN       3'h4
`define BRPS_DP_POST      3'h5
`define BRPS_DP_LOCK      3'h6
// Clock and timing figures
`define BRPS_CLK_NS       10
`define BRPS_SEC_NS       1000000000
`define BRPS_SEC_CYC      (`BRPS_SEC_NS / `BRPS_CLK_NS)
`define BRPS_STAB_S       16'h000A
`define BRPS_POST_S       16'h000F
`define BRPS_PILOT_LONG_S 16'h000A
`define BRPS_PILOT_SHT_S  16'h0004
`define BRPS_TEST_LONG_S  16'h0008
`define BRPS_TEST_SHT_S   16'h0003
`define BRPS_FLAMEOUT_S   16'h000F
`define BRPS_MAIN_BASE_S  16'h000A
`define BRPS_MAIN_CLIP_S  16'h000F
`define BRPS_MAIN_JMP_S   16'h001E
`define BRPS_MSG_HOLD_S   16'h003C
`define BRPS_SEC_PER_MIN  16'h003C
`endif

// *** core/brps_seq.sv ***
// Burner run, postpurge and test-selector sequencer with an APB register slave.
// Assumes field pins arrive asynchronously; straps read 1 when intact.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "brps_regs.svh"

module brps_seq #(
  parameter int unsigned SEC_CYC = `BRPS_SEC_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        demand_in,
  input  wire logic        test_in,
  input  wire logic        flame_in,
  input  wire logic        high_fire_sw,
  input  wire logic        low_fire_sw,
  input  wire logic        pilot_trial_strap,
  input  wire logic        main_trial_strap,
  input  wire logic        interlock_check_strap,
  input  wire logic        main_alt_term,
  input  wire logic        jumper_pilot_main,
  input  wire logic        jumper_main_start,
  input  wire logic        jumper_blower_main,
  output logic             blower_out,
  output logic             frate_high,
  output logic             frate_low,
  output logic             frate_mod,
  output logic             damper_out,
  output logic             pilot_out,
  output logic             main_out,
  output logic             lockout_out,
  output logic [2:0]       disp_phase,
  output logic             disp_timed,
  output logic [7:0]       disp_min,
  output logic [5:0]       disp_sec,
  output logic             disp_arrow,
  output logic [1:0]       disp_code,
  output logic             disp_preempt,
  output logic             disp_paren
);

  // Display phase of a sequence state
  function automatic logic [2:0] phase_of(input brps_pkg::brps_state_type s);
    case (s)
      brps_pkg::ST_STANDBY: phase_of = `BRPS_DP_STANDBY;
      brps_pkg::ST_PILOT:   phase_of = `BRPS_DP_PILOT;
      brps_pkg::ST_MAIN:    phase_of = `BRPS_DP_MAIN;
      brps_pkg::ST_STAB,
      brps_pkg::ST_RUN:     phase_of = `BRPS_DP_RUN;
      brps_pkg::ST_POST:    phase_of = `BRPS_DP_POST;
      brps_pkg::ST_LOCKOUT: phase_of = `BRPS_DP_LOCK;
      default:              phase_of = `BRPS_DP_PURGE;
    endcase
  endfunction : phase_of

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; stage one is read only by stage two
  logic [10:0] sync1_q;
  logic [10:0] sync2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 11'h000;
      sync2_q <= 11'h000;
    end else begin
      sync1_q <= {jumper_blower_main, jumper_main_start, jumper_pilot_main, main_alt_term,
                  interlock_check_strap, main_trial_strap, pilot_trial_strap,
                  low_fire_sw, high_fire_sw, flame_in, demand_in};
      sync2_q <= sync1_q;
    end
  end
  logic test_s1_q;
  logic test_s2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_s1_q <= 1'b0;
      test_s2_q <= 1'b0;
    end else begin
      test_s1_q <= test_in;
      test_s2_q <= test_s1_q;
    end
  end

  logic demand;
  logic flame;
  logic hi_sw;
  logic lo_sw;
  logic pilot_strap;
  logic main_strap;
  logic ilck_strap;
  logic alt_term;
  logic jmp_any;
  logic jmp_bm;
  assign demand      = sync2_q[0];
  assign flame       = sync2_q[1];
  assign hi_sw       = sync2_q[2];
  assign lo_sw       = sync2_q[3];
  assign pilot_strap = sync2_q[4];
  assign main_strap  = sync2_q[5];
  assign ilck_strap  = sync2_q[6];
  assign alt_term    = sync2_q[7];
  assign jmp_any     = sync2_q[8] | sync2_q[9];
  assign jmp_bm      = sync2_q[10];

  //////////////////////////////////////////////////////////////////////////////
  // APB registers
  logic [1:0]  ctrl_q;
  logic [15:0] purge_q;
  logic [3:0]  msg_q;
  logic        clr_req_q;
  logic        wr_acc;
  logic        setup;
  assign wr_acc = psel & penable & pwrite;
  assign setup  = psel & ~penable;

  // Writable configuration; lockout clear is a one-cycle pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= `BRPS_CTRL_RST;
      purge_q   <= `BRPS_PURGE_RST;
      msg_q     <= 4'h0;
      clr_req_q <= 1'b0;
    end else begin
      clr_req_q <= wr_acc && paddr == `BRPS_CTRL_OFS && pwdata[`BRPS_CTRL_CLR];
      if (wr_acc && paddr == `BRPS_CTRL_OFS) ctrl_q <= pwdata[1:0];
      if (wr_acc && paddr == `BRPS_PURGE_OFS) purge_q <= pwdata[15:0];
      if (wr_acc && paddr == `BRPS_MSG_OFS) msg_q <= pwdata[3:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // One-second timebase
  logic [31:0] pre_q;
  logic        tick;
  assign tick = (pre_q == SEC_CYC - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pre_q <= 32'h0000_0000;
    else pre_q <= tick ? 32'h0000_0000 : pre_q + 32'h0000_0001;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequence state machine
  brps_pkg::brps_state_type st_q;
  logic [15:0] tmr_q;
  logic [15:0] fout_q;
  logic [15:0] pilot_len;
  logic [15:0] test_win;
  logic [15:0] main_len;
  logic        test_pilot;
  logic        pilot_hold;

  assign pilot_len  = pilot_strap ? `BRPS_PILOT_LONG_S : `BRPS_PILOT_SHT_S;
  assign test_win   = pilot_strap ? `BRPS_TEST_LONG_S : `BRPS_TEST_SHT_S;
  // Alternate terminal keeps the short trial
  assign main_len   = (alt_term || main_strap) ? `BRPS_MAIN_BASE_S :
                      (jmp_bm ? `BRPS_MAIN_JMP_S : `BRPS_MAIN_CLIP_S);
  assign test_pilot = test_s2_q & ~(ctrl_q[`BRPS_CTRL_LOCKV] & jmp_any);
  assign pilot_hold = test_pilot & (tmr_q < test_win);

  // Timers count whole seconds; holds keep tmr_q so release resumes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= brps_pkg::ST_STANDBY;
      tmr_q  <= 16'h0000;
      fout_q <= 16'h0000;
    end else begin
      case (st_q)
        brps_pkg::ST_STANDBY: begin
          tmr_q <= 16'h0000;
          if (demand) st_q <= brps_pkg::ST_PRE_HIGH;
        end
        brps_pkg::ST_PRE_HIGH: begin
          if (hi_sw && !test_s2_q) st_q <= brps_pkg::ST_PURGE;
        end
        brps_pkg::ST_PURGE: begin
          if (tmr_q >= purge_q) begin
            st_q  <= brps_pkg::ST_PRE_LOW;
            tmr_q <= 16'h0000;
          end else if (tick && !test_s2_q) begin
            tmr_q <= tmr_q + 16'h0001;
          end
        end
        brps_pkg::ST_PRE_LOW: begin
          if (lo_sw && !test_s2_q) st_q <= brps_pkg::ST_PILOT;
        end
        brps_pkg::ST_PILOT: begin
          if (!pilot_hold) fout_q <= 16'h0000;
          else if (flame) fout_q <= 16'h0000;
          else if (tick) fout_q <= fout_q + 16'h0001;
          if (pilot_hold && fout_q >= `BRPS_FLAMEOUT_S) begin
            st_q <= brps_pkg::ST_LOCKOUT;
          end else if (tmr_q >= pilot_len) begin
            tmr_q <= 16'h0000;
            st_q  <= flame ? brps_pkg::ST_MAIN : brps_pkg::ST_LOCKOUT;
          end else if (tick && !pilot_hold) begin
            tmr_q <= tmr_q + 16'h0001;
          end
        end
        brps_pkg::ST_MAIN: begin
          if (tmr_q >= main_len) begin
            tmr_q <= 16'h0000;
            st_q  <= flame ? brps_pkg::ST_STAB : brps_pkg::ST_LOCKOUT;
          end else if (tick) begin
            tmr_q <= tmr_q + 16'h0001;
          end
        end
        brps_pkg::ST_STAB: begin
          if (!flame) st_q <= brps_pkg::ST_LOCKOUT;
          else if (!demand) begin
            st_q  <= brps_pkg::ST_POST;
            tmr_q <= 16'h0000;
          end else if (tmr_q >= `BRPS_STAB_S) st_q <= brps_pkg::ST_RUN;
          else if (tick) tmr_q <= tmr_q + 16'h0001;
        end
        brps_pkg::ST_RUN: begin
          tmr_q <= 16'h0000;
          if (!flame) st_q <= brps_pkg::ST_LOCKOUT;
          else if (!demand) st_q <= brps_pkg::ST_POST;
        end
        brps_pkg::ST_POST: begin
          if (tmr_q >= `BRPS_POST_S) begin
            st_q  <= brps_pkg::ST_STANDBY;
            tmr_q <= 16'h0000;
          end else if (tick) begin
            tmr_q <= tmr_q + 16'h0001;
          end
        end
        brps_pkg::ST_LOCKOUT: begin
          tmr_q  <= 16'h0000;
          fout_q <= 16'h0000;
          if (clr_req_q) st_q <= brps_pkg::ST_STANDBY;
        end
        default: st_q <= brps_pkg::ST_LOCKOUT;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Field outputs, registered from state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blower_out  <= 1'b0;
      frate_high  <= 1'b0;
      frate_low   <= 1'b0;
      frate_mod   <= 1'b0;
      damper_out  <= 1'b0;
      pilot_out   <= 1'b0;
      main_out    <= 1'b0;
      lockout_out <= 1'b0;
    end else begin
      blower_out  <= st_q != brps_pkg::ST_STANDBY && st_q != brps_pkg::ST_LOCKOUT;
      frate_high  <= st_q == brps_pkg::ST_PRE_HIGH || st_q == brps_pkg::ST_PURGE;
      frate_low   <= st_q == brps_pkg::ST_PRE_LOW || st_q == brps_pkg::ST_PILOT ||
                     st_q == brps_pkg::ST_MAIN || st_q == brps_pkg::ST_STAB ||
                     (st_q == brps_pkg::ST_RUN && test_s2_q);
      frate_mod   <= st_q == brps_pkg::ST_RUN && !test_s2_q &&
                     !ctrl_q[`BRPS_CTRL_ONOFF];
      damper_out  <= st_q == brps_pkg::ST_RUN && ctrl_q[`BRPS_CTRL_ONOFF];
      pilot_out   <= st_q == brps_pkg::ST_PILOT || st_q == brps_pkg::ST_MAIN;
      main_out    <= st_q == brps_pkg::ST_MAIN || st_q == brps_pkg::ST_STAB ||
                     st_q == brps_pkg::ST_RUN;
      lockout_out <= st_q == brps_pkg::ST_LOCKOUT;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status display: phase, timer, submenu marker, message priority
  logic [15:0] msg_tmr_q;
  logic        timed;
  // Drive-to-fire steps show as purge, with a zero timer
  assign timed = st_q == brps_pkg::ST_PRE_HIGH || st_q == brps_pkg::ST_PURGE ||
                 st_q == brps_pkg::ST_PRE_LOW || st_q == brps_pkg::ST_PILOT ||
                 st_q == brps_pkg::ST_MAIN || st_q == brps_pkg::ST_POST;

  // Age of the selectable message; resets whenever a preempt takes over
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) msg_tmr_q <= 16'h0000;
    else if (disp_preempt) msg_tmr_q <= 16'h0000;
    else if (tick && msg_tmr_q < `BRPS_MSG_HOLD_S) msg_tmr_q <= msg_tmr_q + 16'h0001;
  end

  // Division is slow but the timer changes once a second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_phase   <= `BRPS_DP_STANDBY;
      disp_timed   <= 1'b0;
      disp_min     <= 8'h00;
      disp_sec     <= 6'h00;
      disp_arrow   <= 1'b0;
      disp_code    <= 2'h0;
      disp_preempt <= 1'b0;
      disp_paren   <= 1'b0;
    end else begin
      disp_phase   <= phase_of(st_q);
      disp_timed   <= timed;
      disp_min     <= timed ? 8'(tmr_q / `BRPS_SEC_PER_MIN) : 8'h00;
      disp_sec     <= timed ? 6'(tmr_q % `BRPS_SEC_PER_MIN) : 6'h00;
      disp_preempt <= (msg_q[`BRPS_MSG_PRE] || msg_q[`BRPS_MSG_LOCK]) &&
                      (disp_preempt || msg_tmr_q >= `BRPS_MSG_HOLD_S);
      disp_paren   <= disp_preempt;
      disp_arrow   <= !disp_preempt && msg_q[1:0] != 2'h0;
      disp_code    <= disp_preempt ? 2'h0 : msg_q[1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB read data and error, prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        pslverr <= 1'b0;
        case (paddr)
          `BRPS_CTRL_OFS:  prdata <= {30'h0000_0000, ctrl_q};
          `BRPS_PURGE_OFS: prdata <= {16'h0000, purge_q};
          `BRPS_MSG_OFS:   prdata <= {28'h000_0000, msg_q};
          `BRPS_STAT_OFS:  prdata <= {tmr_q, 3'h0, pilot_hold, disp_preempt, ilck_strap,
                                      main_strap, pilot_strap, test_s2_q, phase_of(st_q), st_q};
          default: begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule : brps_seq
